// file: design/csrs_pkg.sv
package csrs_pkg;

    // ****************************************
    // bus address and command codes
    // ****************************************
    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_INLIMIT = 8'h3f;
    localparam logic [7:0] CMD_MAKER = 8'hfe;
    localparam logic [7:0] CMD_PART = 8'hff;

    // ****************************************
    // setting registers: reset values and fields
    // ****************************************
    localparam logic [15:0] CURRENT_RST = 16'h0000;
    localparam logic [15:0] VOLTAGE_RST = 16'h0000;
    localparam logic [15:0] INLIMIT_RST = 16'h0080;
    localparam logic [15:0] CURRENT_MASK = 16'h1f80;
    localparam logic [15:0] VOLTAGE_MASK = 16'h7ff0;
    localparam logic [15:0] INLIMIT_MASK = 16'h1f80;
    // voltage word counts millivolts: 1024 mV and 19200 mV
    localparam logic [15:0] VOLT_MIN_MV = 16'h0400;
    localparam logic [15:0] VOLT_MAX_MV = 16'h4b00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 5;
    localparam longint TIMEOUT_S = 170;
    localparam longint TIMEOUT_CYC = TIMEOUT_S * 64'd1000000000 / CLK_NS;
    localparam int SCL_PERIOD_NS = 1000;
    localparam int QTR_CYC = SCL_PERIOD_NS / 4 / CLK_NS;
    localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);

    // ****************************************
    // controller register map (apb)
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_WDATA = 8'h04;
    localparam logic [7:0] A_RDATA = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0c;
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_CMD_LSB = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [5:0] {
        L_IDLE = 6'b000001,
        L_RX = 6'b000010,
        L_ACK = 6'b000100,
        L_TX = 6'b001000,
        L_TXACK = 6'b010000,
        L_WAIT = 6'b100000
    } csrs_lstate_t;

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclP;
        logic sdaS1;
        logic sdaS2;
        logic sdaP;
        csrs_lstate_t st;
        logic [3:0] bitCnt;
        logic [1:0] idx;
        logic rd;
        logic hostAck;
        logic sdaOeN;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic [7:0] low;
        logic [15:0] cur;
        logic [15:0] volt;
        logic [15:0] inl;
        logic wrTog;
        logic wrCur;
        logic wrVolt;
        logic voltBad;
    } csrs_link_t;

    typedef struct packed {
        logic tS1;
        logic tS2;
        logic tP;
        logic curW;
        logic voltW;
        logic en;
        logic [35:0] tmr;
        logic [15:0] cur;
        logic [15:0] volt;
        logic [15:0] inl;
    } csrs_sys_t;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_START = 5'b00010,
        H_SEND = 5'b00100,
        H_RECV = 5'b01000,
        H_STOP = 5'b10000
    } csrs_hstate_t;

    typedef struct packed {
        csrs_hstate_t st;
        logic [8:0] div;
        logic [1:0] ph;
        logic [3:0] bitCnt;
        logic [2:0] step;
        logic [7:0] sh;
        logic sdaS1;
        logic sdaS2;
        logic ackBit;
        logic sclOeN;
        logic sdaOeN;
        logic rd;
        logic nack;
        logic [7:0] cmd;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [31:0] prdata;
    } csrs_host_t;

endpackage : csrs_pkg

// file: design/csrs_if.sv
`timescale 1ns/10ps
interface csrs_if;
    logic scl;
    logic sda;
    logic sclOut;
    logic sclOeN;
    logic hSdaOut;
    logic hSdaOeN;
    logic dSdaOut;
    logic dSdaOeN;

    // wired-and with pull-ups: a released line reads high
    assign scl = sclOeN | sclOut;
    assign sda = (hSdaOeN | hSdaOut) & (dSdaOeN | dSdaOut);

    modport host (
        output sclOut,
        output sclOeN,
        output hSdaOut,
        output hSdaOeN,
        input sda
    );

    modport device (
        input scl,
        input sda,
        output dSdaOut,
        output dSdaOeN
    );
endinterface : csrs_if

// file: design/csrs_host.sv
`timescale 1ns/10ps
module csrs_host
    import csrs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    csrs_if.host bus
);

    csrs_host_t hr;
    csrs_host_t hn;
    logic tick;
    logic busy;

    // ****************************************
    // transaction script
    // ****************************************
    function automatic csrs_hstate_t stepOp(input logic [2:0] s, input logic rd);
        case (s)
            3'h0: stepOp = H_START;
            3'h1, 3'h2: stepOp = H_SEND;
            3'h3: stepOp = rd ? H_START : H_SEND;
            3'h4: stepOp = H_SEND;
            3'h5, 3'h6: stepOp = rd ? H_RECV : H_STOP;
            default: stepOp = H_STOP;
        endcase
    endfunction : stepOp

    function automatic logic [7:0] stepByte(input logic [2:0] s, input logic rd,
                                            input logic [7:0] cmd, input logic [15:0] wd);
        case (s)
            3'h1: stepByte = {DEV_ADDR, 1'b0};
            3'h2: stepByte = cmd;
            3'h3: stepByte = wd[7:0];
            3'h4: stepByte = rd ? {DEV_ADDR, 1'b1} : wd[15:8];
            default: stepByte = 8'hff;
        endcase
    endfunction : stepByte

    assign busy = hr.st != H_IDLE;
    assign tick = hr.div == QTR_LAST;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr != A_CTRL) & (paddr != A_WDATA)
                   & (paddr != A_RDATA) & (paddr != A_STATUS);
    assign prdata = hr.prdata;
    assign bus.sclOut = 1'b0;
    assign bus.sclOeN = hr.sclOeN;
    assign bus.hSdaOut = 1'b0;
    assign bus.hSdaOeN = hr.sdaOeN;

    always_comb begin
        hn = hr;
        hn.sdaS1 = bus.sda;
        hn.sdaS2 = hr.sdaS1;

        // ****************************************
        // apb slave
        // ****************************************
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                A_CTRL: hn.prdata = {16'h0000, hr.cmd, 6'h00, hr.rd, 1'b0};
                A_WDATA: hn.prdata = {16'h0000, hr.wdata};
                A_RDATA: hn.prdata = {16'h0000, hr.rdata};
                A_STATUS: hn.prdata = {30'h0, hr.nack, busy};
                default: hn.prdata = 32'h0;
            endcase
        end
        // writes while busy are dropped so a running transfer stays intact
        if (psel & penable & pwrite & ~busy) begin
            if (paddr == A_WDATA) begin
                hn.wdata = pwdata[15:0];
            end
            if (paddr == A_CTRL) begin
                hn.cmd = pwdata[CTRL_CMD_LSB +: 8];
                hn.rd = pwdata[CTRL_READ];
                if (pwdata[CTRL_GO]) begin
                    hn.nack = 1'b0;
                    hn.step = 3'h0;
                    hn.st = H_START;
                    hn.ph = 2'h0;
                    hn.div = 9'h0;
                    hn.bitCnt = 4'h0;
                end
            end
        end

        // ****************************************
        // bit engine: four quarter phases per scl clock
        // ****************************************
        if (busy) begin
            hn.div = tick ? 9'h0 : hr.div + 9'h1;
        end
        if (busy && tick) begin
            hn.ph = hr.ph + 2'h1;
            case (hr.ph)
                2'h0: begin
                    hn.sclOeN = 1'b0;
                    case (hr.st)
                        H_START: hn.sdaOeN = 1'b1;
                        H_STOP: hn.sdaOeN = 1'b0;
                        H_SEND: hn.sdaOeN = (hr.bitCnt == 4'h8) | hr.sh[7];
                        // low byte acked, high byte nacked
                        default: hn.sdaOeN = (hr.bitCnt != 4'h8) | (hr.step == 3'h6);
                    endcase
                end
                2'h1: hn.sclOeN = 1'b1;
                2'h2: begin
                    if (hr.st == H_START) begin
                        hn.sdaOeN = 1'b0;
                    end else if (hr.st == H_STOP) begin
                        hn.sdaOeN = 1'b1;
                    end else if (hr.bitCnt == 4'h8) begin
                        hn.ackBit = hr.sdaS2;
                    end else begin
                        hn.sh = {hr.sh[6:0], hr.sdaS2};
                    end
                end
                default: begin
                    if (hr.st == H_STOP) begin
                        hn.st = H_IDLE;
                    end else begin
                        hn.sclOeN = 1'b0;
                        hn.bitCnt = hr.bitCnt + 4'h1;
                        if (hr.st == H_RECV && hr.step == 3'h5) begin
                            hn.rdata[7:0] = hr.sh;
                        end
                        if (hr.st == H_RECV && hr.step == 3'h6) begin
                            hn.rdata[15:8] = hr.sh;
                        end
                        if (hr.st == H_START || hr.bitCnt == 4'h8) begin
                            // one script for both formats, ended by a stop
                            hn.step = hr.step + 3'h1;
                            hn.st = stepOp(hn.step, hr.rd);
                            hn.sh = stepByte(hn.step, hr.rd, hr.cmd, hr.wdata);
                            hn.bitCnt = 4'h0;
                            if (hr.st == H_SEND && hr.ackBit) begin
                                hn.nack = 1'b1;
                                hn.st = H_STOP;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hr <= '0;
            hr.st <= H_IDLE;
            hr.sclOeN <= 1'b1;
            hr.sdaOeN <= 1'b1;
            hr.sdaS1 <= 1'b1;
            hr.sdaS2 <= 1'b1;
        end else begin
            hr <= hn;
        end
    end

endmodule : csrs_host

// file: design/csrs_device.sv
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
// Operation
// - answer only at address 0001001
// - never master; never drive scl
// - only read-word and write-word transfers
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - sda changes only while scl low
// - bytes msb first, sampled on scl rise
// - ninth clock carries receiver acknowledge
// - write-word: address, command, low, high, acked
// - whole transaction between start and stop
// - 0x14 charge current, resets to zero
// - 0x15 charge voltage, resets to zero
// - 0x3f input limit, resets to 0x0080
// - 0xfe maker, 0xff part identity, read-only
// - identity reads always return fixed codes
// - read-word: repeated start, low acked, high nacked
// - 170 s without current or voltage writes stops charging
// - out-of-range voltage clears it, stops charging
module csrs_device
    import csrs_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h00a5, // arbitrary
    parameter logic [15:0] PART_ID = 16'h005a, // arbitrary
    parameter logic [35:0] TIMEOUT_CYCLES = TIMEOUT_CYC[35:0]
) (
    input wire logic clk,
    input wire logic linkClk,
    input wire logic nrst,
    csrs_if.device bus,
    output logic [15:0] charge_current_setting,
    output logic [15:0] charge_voltage_setting,
    output logic [15:0] inputLimit,
    output logic chargeEnable
);

    csrs_link_t lr;
    csrs_link_t ln;
    csrs_sys_t sr;
    csrs_sys_t sn;
    logic rise;
    logic fall;
    logic startC;
    logic stopC;
    logic [15:0] rdData;
    logic [15:0] wrWord;

    // ****************************************
    // register read decode
    // ****************************************
    function automatic logic [15:0] readReg(input logic [7:0] cmd, input logic [15:0] cur,
                                            input logic [15:0] volt, input logic [15:0] inl);
        case (cmd)
            CMD_CURRENT: readReg = cur;
            CMD_VOLTAGE: readReg = volt;
            CMD_INLIMIT: readReg = inl;
            CMD_MAKER: readReg = MAKER_ID;
            CMD_PART: readReg = PART_ID;
            default: readReg = 16'h0000;
        endcase
    endfunction : readReg

    assign rdData = readReg(lr.cmd, lr.cur, lr.volt, lr.inl);
    assign wrWord = {lr.sh, lr.low};

    // open drain: only sda is ever pulled, scl has no driver here
    assign bus.dSdaOut = 1'b0;
    assign bus.dSdaOeN = lr.sdaOeN;

    assign charge_current_setting = sr.cur;
    assign charge_voltage_setting = sr.volt;
    assign inputLimit = sr.inl;
    assign chargeEnable = sr.en;

    // ****************************************
    // link side (linkClk): bus decoder
    // ****************************************
    always_comb begin
        ln = lr;
        ln.sclS1 = bus.scl;
        ln.sclS2 = lr.sclS1;
        ln.sdaS1 = bus.sda;
        ln.sdaS2 = lr.sdaS1;
        ln.sclP = lr.sclS2;
        ln.sdaP = lr.sdaS2;
        rise = lr.sclS2 & ~lr.sclP;
        fall = ~lr.sclS2 & lr.sclP;
        startC = lr.sclS2 & lr.sclP & lr.sdaP & ~lr.sdaS2;
        stopC = lr.sclS2 & lr.sclP & ~lr.sdaP & lr.sdaS2;

        if (startC) begin
            // a repeated start restarts the address phase too
            ln.st = L_RX;
            ln.bitCnt = 4'h0;
            ln.idx = 2'h0;
            ln.sdaOeN = 1'b1;
        end else if (stopC) begin
            ln.st = L_IDLE;
            ln.sdaOeN = 1'b1;
        end else begin
            case (lr.st)
                L_RX: begin
                    if (rise) begin
                        ln.sh = {lr.sh[6:0], lr.sdaS2};
                        ln.bitCnt = lr.bitCnt + 4'h1;
                    end else if (fall && lr.bitCnt == 4'h8) begin
                        ln.st = L_ACK;
                        ln.sdaOeN = 1'b0;
                        case (lr.idx)
                            2'h0: begin
                                ln.rd = lr.sh[0];
                                if (lr.sh[7:1] != DEV_ADDR) begin
                                    ln.st = L_WAIT;
                                    ln.sdaOeN = 1'b1;
                                end
                            end
                            2'h1: ln.cmd = lr.sh;
                            2'h2: ln.low = lr.sh;
                            default: begin
                                // high byte completes the word write
                                ln.wrTog = ~lr.wrTog;
                                ln.wrCur = 1'b0;
                                ln.wrVolt = 1'b0;
                                ln.voltBad = 1'b0;
                                case (lr.cmd)
                                    CMD_CURRENT: begin
                                        ln.cur = wrWord & CURRENT_MASK;
                                        ln.wrCur = 1'b1;
                                    end
                                    CMD_VOLTAGE: begin
                                        if (wrWord < VOLT_MIN_MV || wrWord > VOLT_MAX_MV) begin
                                            ln.volt = VOLTAGE_RST;
                                            ln.voltBad = 1'b1;
                                        end else begin
                                            ln.volt = wrWord & VOLTAGE_MASK;
                                            ln.wrVolt = 1'b1;
                                        end
                                    end
                                    CMD_INLIMIT: ln.inl = wrWord & INLIMIT_MASK;
                                    // identity and unknown codes: acked, nothing stored
                                    default: ln.cur = lr.cur;
                                endcase
                            end
                        endcase
                    end
                end
                L_ACK: begin
                    if (fall) begin
                        ln.sdaOeN = 1'b1;
                        ln.bitCnt = 4'h0;
                        if (lr.idx == 2'h3) begin
                            ln.st = L_WAIT;
                        end else if (lr.idx == 2'h0 && lr.rd) begin
                            ln.st = L_TX;
                            ln.idx = 2'h2;
                            ln.sh = rdData[7:0];
                            ln.sdaOeN = rdData[7];
                        end else begin
                            ln.st = L_RX;
                            ln.idx = lr.idx + 2'h1;
                        end
                    end
                end
                L_TX: begin
                    if (rise) begin
                        ln.sh = {lr.sh[6:0], 1'b0};
                        ln.bitCnt = lr.bitCnt + 4'h1;
                    end else if (fall) begin
                        if (lr.bitCnt == 4'h8) begin
                            ln.sdaOeN = 1'b1;
                            ln.st = L_TXACK;
                        end else begin
                            ln.sdaOeN = lr.sh[7];
                        end
                    end
                end
                L_TXACK: begin
                    if (rise) begin
                        ln.hostAck = ~lr.sdaS2;
                    end else if (fall) begin
                        if (lr.hostAck && lr.idx == 2'h2) begin
                            ln.st = L_TX;
                            ln.idx = 2'h3;
                            ln.bitCnt = 4'h0;
                            ln.sh = rdData[15:8];
                            ln.sdaOeN = rdData[15];
                        end else begin
                            ln.st = L_WAIT;
                        end
                    end
                end
                L_IDLE, L_WAIT: ln.st = lr.st;
                default: ln.st = L_IDLE;
            endcase
        end
    end

    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            lr <= '0;
            lr.st <= L_IDLE;
            lr.sdaOeN <= 1'b1;
            lr.cur <= CURRENT_RST;
            lr.volt <= VOLTAGE_RST;
            lr.inl <= INLIMIT_RST;
        end else begin
            lr <= ln;
        end
    end

    // ****************************************
    // system side (clk): mirrors and charge watchdog
    // ****************************************
    // link registers move only together with wrTog, so they are stable
    // by the time the synchronised toggle is seen here
    always_comb begin
        sn = sr;
        sn.tS1 = lr.wrTog;
        sn.tS2 = sr.tS1;
        sn.tP = sr.tS2;
        sn.tmr = sr.tmr + 36'h1;
        if (sr.tmr >= TIMEOUT_CYCLES - 36'h1) begin
            sn.tmr = 36'h0;
            sn.curW = 1'b0;
            sn.voltW = 1'b0;
        end
        // a write landing on the expiry cycle still counts
        if (sr.tS2 != sr.tP) begin
            sn.cur = lr.cur;
            sn.volt = lr.volt;
            sn.inl = lr.inl;
            if (lr.wrCur) begin
                sn.curW = 1'b1;
                sn.tmr = 36'h0;
            end
            if (lr.wrVolt) begin
                sn.voltW = 1'b1;
                sn.tmr = 36'h0;
            end
            if (lr.voltBad) begin
                sn.voltW = 1'b0;
                sn.tmr = 36'h0;
            end
        end
        // zero current also means no charging
        sn.en = sn.curW & sn.voltW & (sn.cur != 16'h0000);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sr <= '0;
            sr.cur <= CURRENT_RST;
            sr.volt <= VOLTAGE_RST;
            sr.inl <= INLIMIT_RST;
        end else begin
            sr <= sn;
        end
    end

endmodule : csrs_device

// file: dv/csrs_chk.sv
`timescale 1ns/10ps
module csrs_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sclOut,
    input wire logic sclOeN,
    input wire logic hSdaOut,
    input wire logic hSdaOeN,
    input wire logic dSdaOut,
    input wire logic dSdaOeN
);
    // ****************************************
    // bus tracking
    // ****************************************
    logic sclQ_reg, sdaQ_reg, busy_reg, rw_reg, condSeen;
    logic [3:0] bitCnt_reg;
    logic [1:0] byteCnt_reg;
    logic [15:0] hiCnt_reg;
    // sda may only move under a high scl as a start or stop
    assign condSeen = scl && sclQ_reg && (sda != sdaQ_reg);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclQ_reg <= 1'b1;
            sdaQ_reg <= 1'b1;
            busy_reg <= 1'b0;
            rw_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            byteCnt_reg <= 2'h0;
            hiCnt_reg <= 16'hffff;
        end else begin
            sclQ_reg <= scl;
            sdaQ_reg <= sda;
            hiCnt_reg <= scl ? hiCnt_reg + {15'h0000, ~&hiCnt_reg} : 16'h0000;
            if (condSeen) begin
                busy_reg <= !sda;
                bitCnt_reg <= 4'h0;
                byteCnt_reg <= 2'h0;
            end else if (scl && !sclQ_reg) begin
                bitCnt_reg <= (bitCnt_reg == 4'h8) ? 4'h0 : bitCnt_reg + 4'h1;
                if (bitCnt_reg == 4'h8)
                    byteCnt_reg <= byteCnt_reg + 2'h1;
                if (bitCnt_reg == 4'h7 && byteCnt_reg == 2'h0)
                    rw_reg <= sda;
            end
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_DEV_IDLE: assert property (!dSdaOeN |-> busy_reg)
        else $error("device drives sda outside a transfer");
    AST_DEV_SCL_LOW: assert property ($changed(dSdaOeN) |-> !scl)
        else $error("device moved sda while scl high");
    AST_HOST_COND: assert property ($changed(hSdaOeN) && scl |-> $past(scl, 4))
        else $error("host moved sda at scl edge");
    AST_SCL_HIGH: assert property ($fell(scl) |-> hiCnt_reg >= 16'h0060)
        else $error("scl high phase too short");
    AST_ADDR_ACK: assert property ($rose(scl) && bitCnt_reg == 4'h8
        && byteCnt_reg == 2'h0 |-> !sda)
        else $error("address not acknowledged");
    AST_WR_ACK: assert property ($rose(scl) && bitCnt_reg == 4'h8 && !rw_reg |-> !sda)
        else $error("write byte not acknowledged");
    AST_RD_NACK: assert property ($rose(scl) && bitCnt_reg == 4'h8 && rw_reg
        && byteCnt_reg == 2'h2 |-> sda)
        else $error("high read byte not closed by nack");
    AST_ACK_LEN: assert property ($rose(scl) && bitCnt_reg == 4'h8 && !rw_reg
        |-> ##[1:200] dSdaOeN)
        else $error("device held ack too long");
endmodule : csrs_chk

// file: dv/charger_smbus_register_slave_tb.sv
`timescale 1ns/10ps
module charger_smbus_register_slave_tb
    import csrs_pkg::*;
;
    localparam logic [15:0] MK_ID = 16'h00c3; // arbitrary
    localparam logic [15:0] PT_ID = 16'h003c; // arbitrary
    localparam logic [35:0] TMO = 36'h4e20;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, chargeEnable;
    logic [15:0] charge_current_setting, charge_voltage_setting, inputLimit;
    logic [8:0] wireSh = 9'h000;
    int nRise = 0;
    int fails = 0;
    int nTests = 0;

    initial forever #2.5 clk = ~clk;
    initial begin
        #7.3;
        forever #40 linkClk = ~linkClk;
    end

    csrs_if csrs_if_inst ();
    csrs_host csrs_host_inst (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(csrs_if_inst));
    csrs_device #(.MAKER_ID(MK_ID), .PART_ID(PT_ID), .TIMEOUT_CYCLES(TMO)) csrs_device_inst (
        .clk(clk), .linkClk(linkClk), .nrst(nrst), .bus(csrs_if_inst),
        .charge_current_setting(charge_current_setting), .charge_voltage_setting(charge_voltage_setting),
        .inputLimit(inputLimit), .chargeEnable(chargeEnable));
    csrs_chk csrs_chk_inst (.clk(clk), .nrst(nrst), .scl(csrs_if_inst.scl),
        .sda(csrs_if_inst.sda), .sclOut(csrs_if_inst.sclOut), .sclOeN(csrs_if_inst.sclOeN),
        .hSdaOut(csrs_if_inst.hSdaOut), .hSdaOeN(csrs_if_inst.hSdaOeN),
        .dSdaOut(csrs_if_inst.dSdaOut), .dSdaOeN(csrs_if_inst.dSdaOeN));

    // wire monitor: bits as sampled by the receiver
    always @(posedge csrs_if_inst.scl) begin
        wireSh <= {wireSh[7:0], csrs_if_inst.sda};
        nRise <= nRise + 1;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic smb(input logic [7:0] c, input logic rd, input logic [15:0] wd,
        output logic [15:0] q);
        logic [31:0] r;
        logic e;
        apb(A_WDATA, 1'b1, {16'h0000, wd}, r, e);
        apb(A_CTRL, 1'b1, {16'h0000, c, 6'h00, rd, 1'b1}, r, e);
        do
            apb(A_STATUS, 1'b0, 32'h0, r, e);
        while (r[STAT_BUSY] !== 1'b0);
        chk("nack", 32'h0, {31'h0, r[STAT_NACK]});
        apb(A_RDATA, 1'b0, 32'h0, r, e);
        q = r[15:0];
    endtask : smb

    task automatic summarize();
        $display("checks %0d errors %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        logic [15:0] q;
        logic [31:0] r;
        logic e;
        int n;
        // reset spans slow link clock edges, not just fast ones
        repeat (3) @(posedge linkClk);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge linkClk);
        chk("current", 32'h0, {16'h0, charge_current_setting});
        chk("voltage", 32'h0, {16'h0, charge_voltage_setting});
        chk("limit", 32'h80, {16'h0, inputLimit});
        chk("idle", 32'h3, {30'h0, csrs_if_inst.scl, csrs_if_inst.sda});
        apb(8'h10, 1'b0, 32'h0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        n = nRise;
        smb(CMD_CURRENT, 1'b0, 16'h0f80, q);
        chk("rises", 32'h26, 32'(nRise - n));
        chk("wire", 32'h3c, {23'h0, wireSh});
        chk("current", 32'h0f80, {16'h0, charge_current_setting});
        smb(CMD_VOLTAGE, 1'b0, 16'h3000, q);
        chk("voltage", 32'h3000, {16'h0, charge_voltage_setting});
        chk("enable", 32'h1, {31'h0, chargeEnable});
        for (n = 0; n < 30000 && chargeEnable !== 1'b0; n++)
            @(posedge clk);
        chk("expire", 32'h0, {31'h0, chargeEnable});
        chk("kept", 32'h0f80, {16'h0, charge_current_setting});
        smb(CMD_VOLTAGE, 1'b0, 16'h3000, q);
        chk("half", 32'h0, {31'h0, chargeEnable});
        smb(CMD_CURRENT, 1'b0, 16'h0f80, q);
        chk("resume", 32'h1, {31'h0, chargeEnable});
        smb(CMD_VOLTAGE, 1'b0, 16'h0100, q);
        chk("badvolt", 32'h0, {16'h0, charge_voltage_setting});
        chk("stop", 32'h0, {31'h0, chargeEnable});
        smb(CMD_INLIMIT, 1'b0, 16'h1f80, q);
        chk("inl", 32'h1f80, {16'h0, inputLimit});
        smb(CMD_MAKER, 1'b0, 16'h1234, q);
        smb(CMD_MAKER, 1'b1, 16'h0000, q);
        chk("maker", {16'h0, MK_ID}, {16'h0, q});
        smb(CMD_PART, 1'b1, 16'h0000, q);
        chk("part", {16'h0, PT_ID}, {16'h0, q});
        summarize();
    end

    initial begin
        repeat (150000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule : charger_smbus_register_slave_tb
